// file: condition_flag_pkg.sv
// Shared constants, field positions and types of the condition flag unit
`default_nettype none

package condition_flag_pkg;

  // ************************************************************
  // Condition flag bit positions, most to least significant
  // ************************************************************
  localparam int FLAG_S = 7;  // Stop-disable
  localparam int FLAG_X = 6;  // Nonmaskable mask
  localparam int FLAG_H = 5;  // Half carry
  localparam int FLAG_I = 4;  // Maskable mask
  localparam int FLAG_N = 3;  // Negative
  localparam int FLAG_Z = 2;  // Zero
  localparam int FLAG_V = 1;  // Overflow
  localparam int FLAG_C = 0;  // Carry or borrow

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0]  FLAGS_RESET = 8'hD0;  // S, X and I set
  localparam logic [7:0]  BYTE_RESET  = 8'h00;
  localparam logic [15:0] WORD_RESET  = 16'h0000;
  localparam logic [31:0] BUS_RESET   = 32'h00000000;

  // ************************************************************
  // Register byte offsets on the register bus
  // ************************************************************
  localparam logic [7:0] OFS_FLAGS    = 8'h00;
  localparam logic [7:0] OFS_ACCUM    = 8'h04;
  localparam logic [7:0] OFS_INDEX    = 8'h08;
  localparam logic [7:0] OFS_COMMAND  = 8'h0C;
  localparam logic [7:0] OFS_STACK    = 8'h10;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h14;
  localparam logic [7:0] OFS_MEM_DATA = 8'h18;

  // Status bits read back from the command register
  localparam int STAT_HALTED = 0;
  localparam int STAT_BUSY   = 1;

  // ************************************************************
  // Arithmetic constants
  // ************************************************************
  localparam logic [3:0]  BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0]  BCD_BYTE_MAX  = 8'h99;
  localparam logic [7:0]  BCD_LOW_FIX   = 8'h06;
  localparam logic [7:0]  BCD_HIGH_FIX  = 8'h60;
  localparam logic [15:0] WORD_ONE      = 16'h0001;

  // ************************************************************
  // Operation codes and sequencer states
  // ************************************************************
  typedef enum logic [3:0] {
    OP_IDLE           = 4'h0,
    OP_ADD_B_TO_A     = 4'h1,
    OP_ADD_WITH_CARRY = 4'h2,
    OP_SUBTRACT       = 4'h3,
    OP_COMPARE        = 4'h4,
    OP_RAISE_FIRST    = 4'h5,
    OP_LOWER_FIRST    = 4'h6,
    OP_RAISE_SECOND   = 4'h7,
    OP_LOWER_SECOND   = 4'h8,
    OP_SHIFT_LEFT     = 4'h9,
    OP_ROTATE_RIGHT   = 4'hA,
    OP_TRANSFER       = 4'hB,
    OP_DECIMAL_ADJUST = 4'hC,
    OP_HALT           = 4'hD,
    OP_RETURN         = 4'hE,
    OP_DIVIDE         = 4'hF
  } op_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_STACK   = 4'b0010,
    ST_VECTOR  = 4'b0100,
    ST_RESTORE = 4'b1000
  } state_t;

endpackage : condition_flag_pkg

`default_nettype wire

// file: alu_link_if.sv
// Operand and result bundle between the sequencer and the flag arithmetic
`default_nettype none

interface alu_link_if;
  import condition_flag_pkg::*;

  op_t         op;
  logic [7:0]  a;
  logic [7:0]  b;
  logic [15:0] x;
  logic [15:0] y;
  logic [7:0]  flags_in;
  logic [7:0]  res_a;
  logic [7:0]  res_b;
  logic [15:0] res_x;
  logic [15:0] res_y;
  logic [7:0]  flags_out;
  logic        wr_a;
  logic        wr_b;
  logic        wr_x;
  logic        wr_y;

  modport core (output op, a, b, x, y, flags_in,
                input  res_a, res_b, res_x, res_y, flags_out, wr_a, wr_b, wr_x, wr_y);
  modport alu  (input  op, a, b, x, y, flags_in,
                output res_a, res_b, res_x, res_y, flags_out, wr_a, wr_b, wr_x, wr_y);
endinterface : alu_link_if

`default_nettype wire

// file: flag_alu.sv
// Combinational arithmetic and condition flag update for one operation
`default_nettype none

module flag_alu
  import condition_flag_pkg::*;
(
  alu_link_if.alu link
);

  // ************************************************************
  // Result and flag computation
  // ************************************************************
  always_comb begin
    logic [8:0] sum;
    logic [4:0] half;
    logic [7:0] r8;
    logic [7:0] f;
    logic       cin;
    logic       nz;
    logic       lo_fix;
    logic       hi_fix;
    sum    = {1'b0, BYTE_RESET};
    half   = 5'h00;
    f      = link.flags_in;
    r8     = link.a;
    cin    = 1'b0;
    nz     = 1'b0;
    lo_fix = 1'b0;
    hi_fix = 1'b0;
    link.res_a = link.a;
    link.res_b = link.b;
    link.res_x = link.x;
    link.res_y = link.y;
    link.wr_a  = 1'b0;
    link.wr_b  = 1'b0;
    link.wr_x  = 1'b0;
    link.wr_y  = 1'b0;
    case (link.op)
      OP_ADD_B_TO_A, OP_ADD_WITH_CARRY: begin
        cin  = (link.op == OP_ADD_WITH_CARRY) & link.flags_in[FLAG_C];
        sum  = {1'b0, link.a} + {1'b0, link.b} + {8'h00, cin};
        half = {1'b0, link.a[3:0]} + {1'b0, link.b[3:0]} + {4'h0, cin};
        f[FLAG_H] = half[4]; // RQ9 RQ10
        f[FLAG_C] = sum[8]; // RQ18
        f[FLAG_V] = (link.a[7] == link.b[7]) & (sum[7] != link.a[7]); // RQ17 RQ22
        r8 = sum[7:0];
        nz = 1'b1;
        link.wr_a = 1'b1;
      end
      OP_SUBTRACT, OP_COMPARE: begin
        sum = {1'b0, link.a} - {1'b0, link.b};
        f[FLAG_C] = sum[8]; // RQ18
        f[FLAG_V] = (link.a[7] != link.b[7]) & (sum[7] != link.a[7]); // RQ17
        r8 = sum[7:0];
        nz = 1'b1;
        link.wr_a = (link.op == OP_SUBTRACT); // RQ15
      end
      OP_RAISE_FIRST, OP_LOWER_FIRST: begin
        link.res_x = (link.op == OP_RAISE_FIRST) ? link.x + WORD_ONE : link.x - WORD_ONE;
        f[FLAG_Z]  = (link.res_x == WORD_RESET); // RQ16
        link.wr_x  = 1'b1;
      end
      OP_RAISE_SECOND, OP_LOWER_SECOND: begin
        link.res_y = (link.op == OP_RAISE_SECOND) ? link.y + WORD_ONE : link.y - WORD_ONE;
        f[FLAG_Z]  = (link.res_y == WORD_RESET); // RQ16
        link.wr_y  = 1'b1;
      end
      OP_SHIFT_LEFT, OP_ROTATE_RIGHT: begin
        r8 = (link.op == OP_SHIFT_LEFT) ? {link.a[6:0], 1'b0}
                                        : {link.flags_in[FLAG_C], link.a[7:1]};
        f[FLAG_C] = (link.op == OP_SHIFT_LEFT) ? link.a[7] : link.a[0]; // RQ18
        f[FLAG_V] = r8[7] ^ f[FLAG_C]; // RQ17
        nz = 1'b1;
        link.wr_a = 1'b1;
      end
      OP_TRANSFER: begin
        link.res_b = link.a; // RQ19
        link.wr_b  = 1'b1;
      end
      OP_DECIMAL_ADJUST: begin
        lo_fix = link.flags_in[FLAG_H] | (link.a[3:0] > BCD_DIGIT_MAX); // RQ10
        hi_fix = link.flags_in[FLAG_C] | (link.a > BCD_BYTE_MAX);
        r8 = link.a + (lo_fix ? BCD_LOW_FIX : BYTE_RESET) + (hi_fix ? BCD_HIGH_FIX : BYTE_RESET);
        f[FLAG_C] = hi_fix;
        nz = 1'b1;
        link.wr_a = 1'b1;
      end
      OP_DIVIDE: begin
        f[FLAG_C] = (link.b == BYTE_RESET); // RQ18
        r8 = f[FLAG_C] ? link.a : link.a / link.b;
        nz = 1'b1;
        link.wr_a = 1'b1;
      end
      default: begin
        f = link.flags_in;
      end
    endcase
    if (nz) begin
      f[FLAG_N] = r8[7]; // RQ14
      f[FLAG_Z] = (r8 == BYTE_RESET); // RQ15
    end
    if (link.wr_a) begin
      link.res_a = r8;
    end
    link.flags_out = f;
  end

endmodule : flag_alu

`default_nettype wire

// file: byte_store.sv
// 64-Kbyte byte memory with big-endian unaligned word port and registered read
`default_nettype none

module byte_store (
  // Clock
  input  wire logic        clk_in,
  // Access
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        we_in,
  input  wire logic        wide_in,
  output var  logic [15:0] rdata_out
);

  logic [7:0]  mem [0:65535];
  wire  [15:0] addr_next = addr_in + 16'h0001;

  // ************************************************************
  // High byte at the lower address, any alignment, address wraps
  // ************************************************************
  always_ff @(posedge clk_in) begin
    if (we_in && wide_in) begin
      mem[addr_in]   <= wdata_in[15:8]; // RQ20
      mem[addr_next] <= wdata_in[7:0]; // RQ20
    end else if (we_in) begin
      mem[addr_in] <= wdata_in[7:0];
    end
    rdata_out <= {mem[addr_in], mem[addr_next]}; // RQ20 RQ21
  end

endmodule : byte_store

`default_nettype wire

// file: condition_flag_unit.sv
// Condition flag register, interrupt masking and one-at-a-time operation sequencer
// Functional notes
// (RQ1) Stop-disable set turns halt into idle op
// (RQ2) Reset sets stop-disable bit
// (RQ3) Reset sets nonmaskable mask to one
// (RQ4) Nonmaskable mask set blocks nonmaskable pin
// (RQ5) Software writes cannot set nonmaskable mask again
// (RQ6) Maskable entry leaves nonmaskable mask alone
// (RQ7) Nonmaskable entry sets both masks after stacking
// (RQ8) Flags stacked first; return restores stacked value
// (RQ9) Half carry is carry out of bit 3
// (RQ10) Only additions update half carry; adjust reads it
// (RQ11) Reset sets maskable mask to one
// (RQ12) Masked maskable requests stay pending until cleared
// (RQ13) Entry sets maskable mask before service starts
// (RQ14) Negative flag copies result top bit
// (RQ15) Zero flag; compare subtracts without storing
// (RQ16) Index step ops touch only zero flag
// (RQ17) Overflow flag on two's complement overflow
// (RQ18) Carry: add carry, borrow, errors, shifts
// (RQ19) Transfers leave flags unchanged
// (RQ20) Big-endian multi-byte storage, no alignment
// (RQ21) Sixteen-bit addresses span 64 Kbytes
// (RQ22) Short signed offsets only for indexing
// (RQ23) One operation completes before the next
// (RQ24) Flag register is eight bits wide
// (RQ25) Flag order S X H I N Z V C
`default_nettype none

module condition_flag_unit
  import condition_flag_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  // Wishbone classic slave
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output var  logic [31:0] WB_DAT_OUT,
  output var  logic        WB_ACK_OUT,
  // Interrupt request pins, active low
  input  wire logic        MASKABLE_REQUEST_PIN_N_IN,
  input  wire logic        NONMASKABLE_REQUEST_PIN_N_IN,
  // Core status
  output var  logic        HALTED_OUT,
  output var  logic        VECTOR_FETCH_OUT,
  output var  logic        VECTOR_NMI_OUT
);

  // ************************************************************
  // Declarations
  // ************************************************************
  state_t      state_reg;
  state_t      state_next;
  logic [7:0]  flags_reg;   // RQ24
  logic [7:0]  flags_next;
  logic [7:0]  acc_a_reg;
  logic [7:0]  acc_b_reg;
  logic [15:0] idx_x_reg;
  logic [15:0] idx_y_reg;
  logic [15:0] sp_reg;
  logic [15:0] sp_next;
  logic [15:0] mem_addr_reg;
  logic        halted_reg;
  logic        halted_next;
  logic        irq_pend_reg;
  logic        irq_pend_next;
  logic        nmi_taking_reg;
  logic        irq_meta_reg;
  logic        irq_sync_reg;
  logic        nmi_meta_reg;
  logic        nmi_sync_reg;
  logic        mem_fresh_reg;
  logic        ack_reg;
  logic [31:0] dat_out_reg;
  logic        vec_fetch_reg;
  logic        vec_nmi_reg;
  logic [15:0] mem_rdata;
  logic [31:0] rd_data;

  alu_link_if link ();

  // Lane merge for a 16-bit register under two byte enables
  function automatic logic [15:0] lanes16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  sel);
    lanes16 = {sel[1] ? new_v[15:8] : old_v[15:8], sel[0] ? new_v[7:0] : old_v[7:0]};
  endfunction : lanes16

  // ************************************************************
  // Bus decode
  // ************************************************************
  wire [5:0] word_idx     = WB_ADR_IN[7:2];
  wire       hit_flags    = (word_idx == OFS_FLAGS[7:2]);
  wire       hit_accum    = (word_idx == OFS_ACCUM[7:2]);
  wire       hit_index    = (word_idx == OFS_INDEX[7:2]);
  wire       hit_command  = (word_idx == OFS_COMMAND[7:2]);
  wire       hit_stack    = (word_idx == OFS_STACK[7:2]);
  wire       hit_mem_addr = (word_idx == OFS_MEM_ADDR[7:2]);
  wire       hit_mem_data = (word_idx == OFS_MEM_DATA[7:2]);
  wire       is_idle      = (state_reg == ST_IDLE);
  wire       bus_req      = WB_CYC_IN & WB_STB_IN;
  // Memory reads wait until the read register holds the current address
  wire       mem_ready    = ~hit_mem_data | WB_WE_IN | mem_fresh_reg;
  wire       take         = bus_req & ~ack_reg & is_idle & mem_ready; // RQ23
  wire       wr_take      = take & WB_WE_IN;

  // ************************************************************
  // Command decode
  // ************************************************************
  wire       cmd_go     = wr_take & hit_command & WB_SEL_IN[0] & ~halted_reg; // RQ23
  wire op_t  cmd_op     = op_t'(WB_DAT_IN[3:0]);
  wire       cmd_return = cmd_go & (cmd_op == OP_RETURN);
  wire       cmd_halt   = cmd_go & (cmd_op == OP_HALT) & ~flags_reg[FLAG_S]; // RQ1
  wire       flag_write = wr_take & hit_flags & WB_SEL_IN[0];

  // ************************************************************
  // Interrupt acceptance, only between operations and bus accesses
  // ************************************************************
  wire int_ok     = is_idle & ~bus_req & ~ack_reg; // RQ23
  wire nmi_accept = int_ok & ~flags_reg[FLAG_X] & ~nmi_sync_reg; // RQ4
  wire irq_accept = int_ok & ~nmi_accept & ~flags_reg[FLAG_I] & irq_pend_reg; // RQ12

  // ************************************************************
  // Software flag write: the nonmaskable mask can only be cleared
  // ************************************************************
  wire [7:0] sw_flags = {WB_DAT_IN[FLAG_S],
                         WB_DAT_IN[FLAG_X] & flags_reg[FLAG_X], // RQ5
                         WB_DAT_IN[5:0]};

  // ************************************************************
  // Memory port: stacking, unstacking or software access
  // ************************************************************
  wire        stack_wr  = (state_reg == ST_STACK);
  wire        sw_mem_wr = wr_take & hit_mem_data;
  wire [15:0] sp_dec    = sp_reg - WORD_ONE;
  wire [15:0] mem_addr  = stack_wr ? sp_dec : (cmd_return ? sp_reg : mem_addr_reg); // RQ21
  wire [15:0] mem_wdata = stack_wr ? {BYTE_RESET, flags_reg}
                                   : lanes16(mem_rdata, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
  wire        mem_we    = stack_wr | sw_mem_wr;
  wire        mem_wide  = ~stack_wr;
  wire        mem_quiet = is_idle & ~mem_we & ~cmd_return & ~(wr_take & hit_mem_addr);

  byte_store u_store (
    .clk_in    (CLK_IN),
    .addr_in   (mem_addr),
    .wdata_in  (mem_wdata),
    .we_in     (mem_we),
    .wide_in   (mem_wide),
    .rdata_out (mem_rdata)
  );

  // ************************************************************
  // Arithmetic unit hookup
  // ************************************************************
  assign link.op       = cmd_go ? cmd_op : OP_IDLE;
  assign link.a        = acc_a_reg;
  assign link.b        = acc_b_reg;
  assign link.x        = idx_x_reg;
  assign link.y        = idx_y_reg;
  assign link.flags_in = flags_reg;

  flag_alu u_alu (
    .link (link.alu)
  );

  // ************************************************************
  // Read data mux
  // ************************************************************
  assign rd_data = hit_flags    ? {24'h000000, flags_reg} :
                   hit_accum    ? {16'h0000, acc_b_reg, acc_a_reg} :
                   hit_index    ? {idx_y_reg, idx_x_reg} :
                   hit_command  ? {30'h0, ~is_idle, halted_reg} :
                   hit_stack    ? {16'h0000, sp_reg} :
                   hit_mem_addr ? {16'h0000, mem_addr_reg} :
                   hit_mem_data ? {16'h0000, mem_rdata} :
                   BUS_RESET;

  // ************************************************************
  // Sequencer next state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (nmi_accept || irq_accept) begin
          state_next = ST_STACK;
        end else if (cmd_return) begin
          state_next = ST_RESTORE;
        end
      end
      ST_STACK: begin
        state_next = ST_VECTOR;
      end
      ST_VECTOR: begin
        state_next = ST_IDLE;
      end
      ST_RESTORE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ************************************************************
  // Flag register next value
  // ************************************************************
  always_comb begin
    flags_next = flags_reg;
    case (state_reg)
      ST_VECTOR: begin
        flags_next[FLAG_I] = 1'b1; // RQ13 RQ7
        flags_next[FLAG_X] = flags_reg[FLAG_X] | nmi_taking_reg; // RQ6 RQ7
      end
      ST_RESTORE: begin
        flags_next = mem_rdata[15:8]; // RQ8
      end
      default: begin
        if (cmd_go) begin
          flags_next = link.flags_out; // RQ19
        end else if (flag_write) begin
          flags_next = sw_flags; // RQ5
        end
      end
    endcase
  end

  // ************************************************************
  // Stack pointer, halt and pending request next values
  // ************************************************************
  assign sp_next = stack_wr ? sp_dec :
                   (state_reg == ST_RESTORE) ? sp_reg + WORD_ONE :
                   (wr_take && hit_stack) ? lanes16(sp_reg, WB_DAT_IN[15:0], WB_SEL_IN[1:0]) :
                   sp_reg;
  assign halted_next   = (halted_reg | cmd_halt) & ~(nmi_accept | irq_accept); // RQ1
  assign irq_pend_next = (irq_pend_reg & ~irq_accept) | ~irq_sync_reg; // RQ12

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      irq_meta_reg <= 1'b1;
      irq_sync_reg <= 1'b1;
      nmi_meta_reg <= 1'b1;
      nmi_sync_reg <= 1'b1;
    end else begin
      irq_meta_reg <= MASKABLE_REQUEST_PIN_N_IN;
      irq_sync_reg <= irq_meta_reg;
      nmi_meta_reg <= NONMASKABLE_REQUEST_PIN_N_IN;
      nmi_sync_reg <= nmi_meta_reg;
    end
  end

  // ************************************************************
  // Control state
  // ************************************************************
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      state_reg      <= ST_IDLE;
      flags_reg      <= FLAGS_RESET; // RQ2 RQ3 RQ11 RQ25
      sp_reg         <= WORD_RESET;
      halted_reg     <= 1'b0;
      irq_pend_reg   <= 1'b0;
      nmi_taking_reg <= 1'b0;
      mem_fresh_reg  <= 1'b0;
    end else begin
      state_reg      <= state_next;
      flags_reg      <= flags_next;
      sp_reg         <= sp_next;
      halted_reg     <= halted_next;
      irq_pend_reg   <= irq_pend_next;
      nmi_taking_reg <= nmi_accept | (nmi_taking_reg & ~is_idle);
      mem_fresh_reg  <= mem_quiet;
    end
  end

  // ************************************************************
  // Accumulators and index registers
  // ************************************************************
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      acc_a_reg <= BYTE_RESET;
      acc_b_reg <= BYTE_RESET;
    end else if (link.wr_a || link.wr_b) begin
      acc_a_reg <= link.res_a;
      acc_b_reg <= link.res_b;
    end else if (wr_take && hit_accum) begin
      acc_a_reg <= WB_SEL_IN[0] ? WB_DAT_IN[7:0] : acc_a_reg;
      acc_b_reg <= WB_SEL_IN[1] ? WB_DAT_IN[15:8] : acc_b_reg;
    end
  end

  // Index registers, also loaded by software
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      idx_x_reg <= WORD_RESET;
      idx_y_reg <= WORD_RESET;
    end else if (link.wr_x || link.wr_y) begin
      idx_x_reg <= link.res_x; // RQ16
      idx_y_reg <= link.res_y; // RQ16
    end else if (wr_take && hit_index) begin
      idx_x_reg <= lanes16(idx_x_reg, WB_DAT_IN[15:0], WB_SEL_IN[1:0]);
      idx_y_reg <= lanes16(idx_y_reg, WB_DAT_IN[31:16], WB_SEL_IN[3:2]);
    end
  end

  // Software memory pointer
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mem_addr_reg <= WORD_RESET;
    end else if (wr_take && hit_mem_addr) begin
      mem_addr_reg <= lanes16(mem_addr_reg, WB_DAT_IN[15:0], WB_SEL_IN[1:0]); // RQ21
    end
  end

  // ************************************************************
  // Bus answer and status outputs
  // ************************************************************
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ack_reg       <= 1'b0;
      dat_out_reg   <= BUS_RESET;
      vec_fetch_reg <= 1'b0;
      vec_nmi_reg   <= 1'b0;
    end else begin
      ack_reg       <= take;
      dat_out_reg   <= (take && !WB_WE_IN) ? rd_data : dat_out_reg;
      vec_fetch_reg <= (state_reg == ST_VECTOR); // RQ7 RQ13
      vec_nmi_reg   <= (state_reg == ST_VECTOR) ? nmi_taking_reg : vec_nmi_reg;
    end
  end

  assign WB_ACK_OUT       = ack_reg;
  assign WB_DAT_OUT       = dat_out_reg;
  assign HALTED_OUT       = halted_reg;
  assign VECTOR_FETCH_OUT = vec_fetch_reg;
  assign VECTOR_NMI_OUT   = vec_nmi_reg;

endmodule : condition_flag_unit

`default_nettype wire

// file: condition_flag_checker.sv
// Port level checker of the condition flag unit
`default_nettype none
module condition_flag_checker (
  input wire logic        CLK_IN, RST_IN, WB_CYC_IN, WB_STB_IN, WB_WE_IN,
  input wire logic [7:0]  WB_ADR_IN,
  input wire logic [31:0] WB_DAT_IN, WB_DAT_OUT,
  input wire logic        WB_ACK_OUT, HALTED_OUT, VECTOR_FETCH_OUT, VECTOR_NMI_OUT
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // ************
  // Bus and core status
  // ************
  a_ack_pulse: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack wider than one cycle");
  a_ack_cause: assert property ($rose(WB_ACK_OUT) |-> $past(WB_CYC_IN && WB_STB_IN))
    else $error("ack without request");
  a_ack_bound: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |-> ##[1:6] WB_ACK_OUT)
    else $error("ack too late");
  a_dat_hold: assert property ($changed(WB_DAT_OUT) |-> WB_ACK_OUT && !WB_WE_IN)
    else $error("read data moved outside a read");
  a_vec_pulse: assert property (VECTOR_FETCH_OUT |=> !VECTOR_FETCH_OUT)
    else $error("vector fetch wider than one cycle");
  a_fetch_runs: assert property (VECTOR_FETCH_OUT |-> !HALTED_OUT)
    else $error("vector fetch while halted");
  a_halt_cause: assert property ($rose(HALTED_OUT) |-> WB_ACK_OUT && $past(WB_WE_IN
    && WB_ADR_IN[7:2] == 6'h03 && WB_DAT_IN[3:0] == 4'hD)) else $error("halt without command");
  a_halt_exit: assert property ($fell(HALTED_OUT) |-> ##[1:3] VECTOR_FETCH_OUT)
    else $error("halt left without entry");
  a_nmi_kind: assert property ($changed(VECTOR_NMI_OUT) |-> ##[0:3] VECTOR_FETCH_OUT)
    else $error("vector kind moved without fetch");
endmodule : condition_flag_checker
bind condition_flag_unit condition_flag_checker u_chk (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .WB_CYC_IN(WB_CYC_IN), .WB_STB_IN(WB_STB_IN), .WB_WE_IN(WB_WE_IN), .WB_ADR_IN(WB_ADR_IN),
  .WB_DAT_IN(WB_DAT_IN), .WB_DAT_OUT(WB_DAT_OUT), .WB_ACK_OUT(WB_ACK_OUT),
  .HALTED_OUT(HALTED_OUT), .VECTOR_FETCH_OUT(VECTOR_FETCH_OUT), .VECTOR_NMI_OUT(VECTOR_NMI_OUT));
`default_nettype wire

// file: tb.sv
// Register level testbench of the condition flag unit
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, mq_n = 1, nq_n = 1;
  logic ack, halt, vf, vn;
  logic [7:0] adr = '0;
  logic [31:0] wd = '0, rdat, q;
  int bad_count = 0, num_checks = 0, fetches = 0;
  always #50 clk = ~clk;
  // Count vector fetch pulses
  always @(posedge clk) if (vf === 1'b1) fetches <= fetches + 1;
  condition_flag_unit DUT (.CLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(wd), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .MASKABLE_REQUEST_PIN_N_IN(mq_n), .NONMASKABLE_REQUEST_PIN_N_IN(nq_n),
    .HALTED_OUT(halt), .VECTOR_FETCH_OUT(vf), .VECTOR_NMI_OUT(vn));
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // One classic cycle, held until ack is sampled
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    {cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    q = rdat;
    {cyc, stb} <= 2'b00;
    if (i >= 20) begin
      bad_count++;
      final_report;
    end
  endtask : bus
  task wr(input logic [7:0] a, input logic [31:0] d); bus(1'b1, a, d); endtask : wr
  task rc(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, q, e);
  endtask : rc
  task op(input logic [7:0] a, b, f, input logic [3:0] c, input logic [31:0] ea, ef);
    wr(8'h04, {16'h0, b, a});
    wr(8'h00, {24'h0, f});
    wr(8'h0C, {28'h0, c});
    rc("accum", 8'h04, ea);
    rc("flags", 8'h00, ef);
  endtask : op
  task waitf(input int n);
    for (int i = 0; i < 40 && fetches < n; i++) @(posedge clk);
    chk("fetches", fetches, n);
    if (fetches < n) final_report;
  endtask : waitf
  // ************
  // Main sequence
  // ************
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    nq_n <= 0;
    rc("flags", 8'h00, 32'hD0);
    repeat (10) @(posedge clk);
    chk("fetches", fetches, 0);
    nq_n <= 1;
    wr(8'h00, 32'h00);
    wr(8'h00, 32'hFF);
    rc("flags", 8'h00, 32'hBF);
    $display("reset and mask test done");
    op(8'h0F, 8'h01, 8'h90, 4'h1, 32'h0110, 32'hB0);
    op(8'h80, 8'h80, 8'h90, 4'h2, 32'h8000, 32'h97);
    op(8'h05, 8'h05, 8'hB0, 4'h4, 32'h0505, 32'hB4);
    op(8'h03, 8'h05, 8'h90, 4'h3, 32'h05FE, 32'h99);
    wr(8'h08, 32'h0003FFFF);
    wr(8'h00, 32'h9B);
    wr(8'h0C, 32'h5);
    rc("flags", 8'h00, 32'h9F);
    wr(8'h0C, 32'h8);
    rc("index", 8'h08, 32'h00020000);
    wr(8'h0C, 32'hB);
    rc("flags", 8'h00, 32'h9B);
    rc("accum", 8'h04, 32'hFEFE);
    op(8'h81, 8'h00, 8'h90, 4'h9, 32'h0002, 32'h93);
    op(8'h01, 8'h00, 8'h91, 4'hA, 32'h0080, 32'h99);
    op(8'h12, 8'h00, 8'hB0, 4'hC, 32'h0018, 32'hB0);
    op(8'h07, 8'h00, 8'h90, 4'hF, 32'h0007, 32'h91);
    $display("arithmetic test done");
    wr(8'h0C, 32'hD);
    rc("status", 8'h0C, 32'h0);
    wr(8'h00, 32'h10);
    wr(8'h0C, 32'hD);
    rc("status", 8'h0C, 32'h1);
    mq_n <= 0;
    repeat (4) @(posedge clk);
    mq_n <= 1;
    repeat (10) @(posedge clk);
    chk("fetches", fetches, 0);
    wr(8'h00, 32'h00);
    waitf(1);
    chk("halted", halt, 1'b0);
    chk("nmi", vn, 1'b0);
    rc("flags", 8'h00, 32'h10);
    rc("stack", 8'h10, 32'hFFFF);
    wr(8'h0C, 32'hE);
    rc("flags", 8'h00, 32'h00);
    rc("stack", 8'h10, 32'h0);
    nq_n <= 0;
    waitf(2);
    nq_n <= 1;
    chk("nmi", vn, 1'b1);
    rc("flags", 8'h00, 32'h50);
    $display("interrupt test done");
    wr(8'h14, 32'hFFFF);
    wr(8'h18, 32'hABCD);
    wr(8'h14, 32'h1);
    wr(8'h18, 32'h1234);
    wr(8'h14, 32'h0);
    rc("memory", 8'h18, 32'hCD12);
    rc("unmapped", 8'h1C, 32'h0);
    $display("memory test done");
    final_report;
  end
endmodule : tb
`default_nettype wire
